//--- hw/pic_ctl.sv
// PMIC system control: events, interrupt, pin mux, config select, I2C slave
`timescale 1ns/10ps
`default_nettype none
module pic_ctl #(
	parameter int          DEB_CYC_0 = pic_pkg::DEB_CYC_0,
	parameter int          DEB_CYC_1 = pic_pkg::DEB_CYC_1,
	parameter int          DEB_CYC_2 = pic_pkg::DEB_CYC_2,
	parameter int          DEB_CYC_3 = pic_pkg::DEB_CYC_3,
	parameter logic [79:0] CFG0_IMG  = pic_pkg::CFG0_DEF,
	parameter logic [79:0] CFG1_IMG  = pic_pkg::CFG1_DEF,
	parameter logic [79:0] CFG2_IMG  = pic_pkg::CFG2_DEF
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Chip enable and option straps
	input  wire logic       chip_enable_pin,
	input  wire logic       i2c_enable,
	input  wire logic       setup_pin_allow,
	// Analog comparator levels
	input  wire logic       thermal_warn_raw,
	input  wire logic       thermal_crit_raw,
	input  wire logic       overvolt_raw,
	input  wire logic       undervolt_raw,
	input  wire logic       overcurrent_raw,
	// Setup select pin sensed under weak pull-up and pull-down
	input  wire logic       setup_select_pin_pu,
	input  wire logic       setup_select_pin_pd,
	// Multi-function pins
	input  wire logic [4:0] pin_in,
	output logic      [4:0] pin_out,
	output logic      [4:0] pin_oe_n,
	output logic      [4:0] pin_pull_enable,
	// Interrupt and buck control
	output logic            interrupt_out_n,
	output logic            buck_enable,
	output logic            buck_pulldown,
	output logic            voltage_set_choice,
	output logic      [7:0] voltage_code,
	output logic      [1:0] op_mode
);
	import pic_pkg::*;

	if (DEB_CYC_0 < 1 || DEB_CYC_1 < 1 || DEB_CYC_2 < 1 ||
		DEB_CYC_3 < 1) begin : g_bad_deb
		$error("pic_ctl: debounce count must be at least one");
	end

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	logic [10:0] s1;
	logic [10:0] s2;
	logic [6:0]  prev;
	logic        en_s, i2c_en_s, allow_s, warn_s, crit_s, uv_s, oc_s;
	logic        pu_s, pd_s, scl_s, sda_s;
	logic        scl_d, sda_d, rail_ok, sys_ok, rl_d;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= '0;
			s2 <= '0;
		end else begin
			s1 <= {chip_enable_pin, i2c_enable, setup_pin_allow,
				thermal_warn_raw, thermal_crit_raw, undervolt_raw,
				overcurrent_raw, setup_select_pin_pu,
				setup_select_pin_pd, pin_in[3], pin_in[4]};
			s2 <= s1;
		end
	end
	assign {en_s, i2c_en_s, allow_s, warn_s, crit_s, uv_s, oc_s,
		pu_s, pd_s, scl_s, sda_s} = s2;
	assign rail_ok = !ov_lvl && !uv_s;
	assign sys_ok = rail_ok;

	// ------------------------------------------------------------
	// Filters for over-voltage and pins 0 to 2
	// ------------------------------------------------------------
	logic [7:0] mem [REG_N];
	logic       ov_lvl, ov_evt;
	logic [2:0] lvl, pin_evt;

	pic_deb #(.LIM0(OV_DEG_CYC), .LIM1(OV_DEG_CYC),
		.LIM2(OV_DEG_CYC), .LIM3(OV_DEG_CYC), .CW(12)) u_ov (
		.clk(clk), .arst_n(arst_n), .raw(overvolt_raw),
		.deb_sel(2'h0), .trig(TRG_RISE), .deb_rise(1'b1),
		.deb_fall(1'b1), .level(ov_lvl), .event_pulse(ov_evt));

	for (genvar g = 0; g < 3; g++) begin : g_pin
		localparam logic [5:0] A1 = 6'(ADR_PIN0) + 6'(2 * g + 1);
		pic_deb #(.LIM0(DEB_CYC_0), .LIM1(DEB_CYC_1),
			.LIM2(DEB_CYC_2), .LIM3(DEB_CYC_3)) u_deb (
			.clk(clk), .arst_n(arst_n), .raw(pin_in[g]),
			.deb_sel(mem[A1][F_DEB_LSB +: 2]),
			.trig(mem[A1][F_TRIG_LSB +: 2]),
			.deb_rise(mem[A1][F_DEBR]), .deb_fall(mem[A1][F_DEBF]),
			.level(lvl[g]), .event_pulse(pin_evt[g]));
	end

	// ------------------------------------------------------------
	// I2C slave
	// ------------------------------------------------------------
	pic_i2c_e   state;
	logic [3:0] cnt;
	logic [7:0] sh, ptr, rd_data;
	logic       rw, sda_low, wr_stb, load_pend, i2c_run;
	logic       scl_rise, scl_fall, start, stop;
	logic [6:0] slv_addr;

	assign i2c_run = en_s && !load_pend && i2c_en_s;
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start = scl_s && scl_d && sda_d && !sda_s;
	assign stop = scl_s && scl_d && !sda_d && sda_s;
	assign slv_addr = mem[6'(ADR_SLV)][6:0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= I_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			sda_low <= 1'b0;
			wr_stb <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (!i2c_run) begin
				state <= I_IDLE;
				sda_low <= 1'b0;
			end else if (start) begin
				state <= I_ADDR;
				cnt <= 4'h0;
				sda_low <= 1'b0;
			end else if (stop) begin
				state <= I_IDLE;
				sda_low <= 1'b0;
			end else if (scl_rise) begin
				case (state)
					I_ADDR, I_REG, I_WDATA: begin
						sh <= {sh[6:0], sda_s};
						cnt <= cnt + 4'h1;
					end
					I_MACK: begin
						if (sda_s) begin
							state <= I_IDLE;
						end else begin
							ptr <= ptr + 8'h01;
							state <= I_AACK;
						end
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state)
					I_ADDR: begin
						if (cnt == 4'h8) begin
							if (sh[7:1] == slv_addr) begin
								sda_low <= 1'b1;
								rw <= sh[0];
								state <= I_AACK;
							end else begin
								state <= I_IDLE;
							end
						end
					end
					I_AACK: begin
						cnt <= 4'h0;
						if (rw) begin
							sh <= rd_data;
							sda_low <= !rd_data[7];
							state <= I_RDATA;
						end else begin
							sda_low <= 1'b0;
							state <= I_REG;
						end
					end
					I_REG: begin
						if (cnt == 4'h8) begin
							ptr <= sh;
							sda_low <= 1'b1;
							state <= I_RACK;
						end
					end
					I_RACK, I_WACK: begin
						sda_low <= 1'b0;
						cnt <= 4'h0;
						if (state == I_WACK)
							ptr <= ptr + 8'h01;
						state <= I_WDATA;
					end
					I_WDATA: begin
						if (cnt == 4'h8) begin
							wr_stb <= 1'b1;
							sda_low <= 1'b1;
							state <= I_WACK;
						end
					end
					I_RDATA: begin
						if (cnt == 4'h7) begin
							sda_low <= 1'b0;
							state <= I_MACK;
						end else begin
							sh <= {sh[6:0], 1'b0};
							sda_low <= !sh[6];
							cnt <= cnt + 4'h1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Events and interrupt
	// ------------------------------------------------------------
	logic [9:0] ev, set, clr, evmask;
	logic       irq_req;

	always_comb begin
		set = {pin_evt, rail_ok && !prev[6], ov_evt, uv_s && !prev[4],
			oc_s && !prev[3], sys_ok && !prev[2], crit_s && !prev[1],
			warn_s && !prev[0]};
		clr = 10'h000;
		if (wr_stb && ptr == ADR_EVT0)
			clr[2:0] = sh[2:0];
		if (wr_stb && ptr == ADR_EVT1)
			clr[6:3] = sh[3:0];
		if (wr_stb && ptr == ADR_EVT2)
			clr[9:7] = sh[2:0];
		evmask = {mem[6'(ADR_MASK2)][2:0], mem[6'(ADR_MASK1)][3:0],
			mem[6'(ADR_MASK0)][2:0]};
		irq_req = |(ev & ~evmask) ||
			(!rail_ok && !mem[6'(ADR_MASK3)][F_M_PGSTAT]) ||
			(warn_s && !mem[6'(ADR_MASK3)][F_M_VRHOT]);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ev <= 10'h000;
			prev <= 7'h00;
		end else if (!en_s) begin
			ev <= 10'h000;
			prev <= 7'h00;
		end else begin
			ev <= (ev & ~clr) | set;
			prev <= {rail_ok, 1'b0, uv_s, oc_s, sys_ok, crit_s, warn_s};
		end
	end

	// ------------------------------------------------------------
	// Register file and configuration load
	// ------------------------------------------------------------
	logic [79:0] cfg_img;

	always_comb begin
		if (!allow_s || (!pu_s && !pd_s))
			cfg_img = CFG0_IMG;
		else if (pu_s && pd_s)
			cfg_img = CFG1_IMG;
		else if (pu_s)
			cfg_img = CFG2_IMG;
		else
			cfg_img = CFG0_IMG;
		case (ptr)
			ADR_STAT0: rd_data = {5'h00, sys_ok, crit_s, warn_s};
			ADR_STAT1: rd_data = {4'h0, rail_ok, ov_lvl, uv_s, oc_s};
			ADR_STAT2: rd_data = {5'h00, lvl};
			ADR_EVT0: rd_data = {5'h00, ev[2:0]};
			ADR_EVT1: rd_data = {4'h0, ev[6:3]};
			ADR_EVT2: rd_data = {5'h00, ev[9:7]};
			default: rd_data = (ptr < 8'(REG_N)) ? mem[ptr[5:0]] : 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < REG_N; k++)
				mem[k] <= 8'h00;
		end else if (en_s && load_pend) begin
			for (int k = 0; k < CFG_N; k++)
				mem[CFG_ADR[k][5:0]] <= cfg_img[8 * k +: 8];
		end else if (wr_stb && ptr < 8'(REG_N)) begin
			mem[ptr[5:0]] <= sh;
		end
	end

	// ------------------------------------------------------------
	// Pin functions and buck control
	// ------------------------------------------------------------
	logic [4:0] next_pin_out, next_pin_oe_n, next_pull;
	logic       en_use, en_lvl, dvc_use, dvc_lvl, rl_lvl, sel;

	always_comb begin
		logic [3:0] md;
		logic       val, drv;
		logic [7:0] c0, c1;
		md = MD_OFF;
		val = 1'b0;
		drv = 1'b0;
		c0 = 8'h00;
		c1 = 8'h00;
		en_use = 1'b0;
		en_lvl = 1'b0;
		dvc_use = 1'b0;
		dvc_lvl = 1'b0;
		rl_lvl = 1'b0;
		next_pin_out = 5'h00;
		next_pin_oe_n = 5'h1F;
		next_pull = 5'h00;
		for (int i = 0; i < 5; i++) begin
			c0 = mem[6'(ADR_PIN0) + 6'(2 * i)];
			c1 = mem[6'(ADR_PIN0) + 6'(2 * i + 1)];
			md = c0[F_MODE_LSB +: 4];
			drv = 1'b1;
			val = 1'b0;
			case (md)
				MD_PG: val = rail_ok ^ c1[F_POL];
				MD_SG: val = sys_ok ^ c1[F_POL];
				MD_IRQ: val = !irq_req ^ c1[F_POL];
				MD_LOW: val = 1'b0;
				MD_HIGH: val = 1'b1;
				default: drv = 1'b0;
			endcase
			if (c0[F_OBUF] && val)
				drv = 1'b0;
			if (i < 3 && !(i == 0 && allow_s)) begin
				if (md == MD_EN) begin
					en_use = 1'b1;
					en_lvl = en_lvl | lvl[i];
				end
				if (md == MD_DVC) begin
					dvc_use = 1'b1;
					dvc_lvl = dvc_lvl | lvl[i];
				end
				if (md == MD_RELOAD)
					rl_lvl = rl_lvl | lvl[i];
			end
			if (i == 0 && allow_s)
				drv = 1'b0;
			if (i >= 3 && i2c_en_s) begin
				drv = (i == 4) && sda_low;
				val = 1'b0;
			end
			if (!en_s)
				drv = 1'b0;
			next_pin_out[i] = val;
			next_pin_oe_n[i] = !drv;
			next_pull[i] = en_s && c1[F_PUPD];
		end
		sel = dvc_use ? dvc_lvl : mem[6'(ADR_BUCK4)][F_VSEL];
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out <= 5'h00;
			pin_oe_n <= 5'h1F;
			pin_pull_enable <= 5'h00;
			interrupt_out_n <= 1'b1;
		end else begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			pin_pull_enable <= next_pull;
			interrupt_out_n <= !(en_s && irq_req);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			load_pend <= 1'b1;
			rl_d <= 1'b0;
			buck_enable <= 1'b0;
			buck_pulldown <= 1'b1;
			voltage_set_choice <= 1'b0;
			voltage_code <= 8'h00;
			op_mode <= 2'h0;
		end else begin
			rl_d <= rl_lvl;
			load_pend <= !en_s || (rl_lvl && !rl_d);
			buck_enable <= en_s && !load_pend && (en_use ? en_lvl :
				mem[6'(ADR_BUCK0)][F_BUCK_EN]);
			buck_pulldown <= !en_s;
			voltage_set_choice <= sel;
			voltage_code <= sel ? mem[6'(ADR_VOUTB)] : mem[6'(ADR_VOUTA)];
			op_mode <= sel ? mem[6'(ADR_BUCK4)][F_BMODE_LSB +: 2] :
				mem[6'(ADR_BUCK4)][F_AMODE_LSB +: 2];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_addr_match;
		i2c_run && !start && !stop && scl_fall && state == I_ADDR &&
			cnt == 4'h8 && sh[7:1] == slv_addr;
	endsequence
	sequence s_data_done;
		i2c_run && !start && !stop && scl_fall && state == I_WDATA &&
			cnt == 4'h8;
	endsequence

	a_event_set: assert property (
		en_s && set != 10'h000 |=> (ev & $past(set)) == $past(set))
		else $error("event flag missed its trigger");
	a_event_hold: assert property (
		en_s && clr == 10'h000 |=> (ev & $past(ev)) == $past(ev))
		else $error("event flag dropped without a clear");
	a_irq_assert: assert property (
		en_s && (ev & ~evmask) != 10'h000 |=> !interrupt_out_n)
		else $error("unmasked event gave no interrupt");
	a_irq_quiet: assert property (
		!irq_req |=> interrupt_out_n)
		else $error("interrupt without an unmasked source");
	a_disable_clear: assert property (
		!en_s |=> ev == 10'h000 && buck_pulldown && !buck_enable)
		else $error("disable left events or buck active");
	a_addr_ack: assert property (
		s_addr_match |=> sda_low && state == I_AACK ##1 !pin_oe_n[4])
		else $error("own address not acknowledged");
	a_write_ack: assert property (
		s_data_done |=> wr_stb && sda_low ##1 !pin_oe_n[4])
		else $error("data byte not stored and acknowledged");
	a_pin_low: assert property (
		en_s && mem[6'(ADR_PIN0) + 6'd2][F_MODE_LSB +: 4] == MD_LOW
		|=> !pin_oe_n[1] && !pin_out[1])
		else $error("drive-low mode did not drive low");
	a_i2c_pins: assert property (
		i2c_en_s |=> pin_oe_n[3])
		else $error("clock pin driven while bus enabled");
	a_uv_event: assert property (
		en_s && uv_s && !prev[4] |=> ev[4])
		else $error("under-voltage event not set at once");
endmodule // pic_ctl
`default_nettype wire

//--- hw/pic_pkg.sv
// Constants, register map and state types of the PMIC system-control block
package pic_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ    = 200;
	localparam int OV_DEG_NS  = 8000;
	localparam int OV_DEG_CYC = (OV_DEG_NS * CLK_MHZ) / 1000;
	localparam int DEB_US_0   = 100;
	localparam int DEB_US_1   = 1000;
	localparam int DEB_US_2   = 10000;
	localparam int DEB_US_3   = 100000;
	localparam int DEB_CYC_0  = DEB_US_0 * CLK_MHZ;
	localparam int DEB_CYC_1  = DEB_US_1 * CLK_MHZ;
	localparam int DEB_CYC_2  = DEB_US_2 * CLK_MHZ;
	localparam int DEB_CYC_3  = DEB_US_3 * CLK_MHZ;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int         REG_N     = 64;
	localparam logic [7:0] ADR_STAT0 = 8'h01;
	localparam logic [7:0] ADR_STAT1 = 8'h02;
	localparam logic [7:0] ADR_STAT2 = 8'h03;
	localparam logic [7:0] ADR_EVT0  = 8'h04;
	localparam logic [7:0] ADR_EVT1  = 8'h05;
	localparam logic [7:0] ADR_EVT2  = 8'h06;
	localparam logic [7:0] ADR_MASK0 = 8'h07;
	localparam logic [7:0] ADR_MASK1 = 8'h08;
	localparam logic [7:0] ADR_MASK2 = 8'h09;
	localparam logic [7:0] ADR_MASK3 = 8'h0A;
	localparam logic [7:0] ADR_SLV   = 8'h0F;
	localparam logic [7:0] ADR_PIN0  = 8'h10;
	localparam logic [7:0] ADR_BUCK0 = 8'h20;
	localparam logic [7:0] ADR_BUCK4 = 8'h24;
	localparam logic [7:0] ADR_VOUTA = 8'h25;
	localparam logic [7:0] ADR_VOUTB = 8'h26;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int F_OBUF      = 0;
	localparam int F_MODE_LSB  = 1;
	localparam int F_TRIG_LSB  = 0;
	localparam int F_POL       = 2;
	localparam int F_PUPD      = 3;
	localparam int F_DEB_LSB   = 4;
	localparam int F_DEBR      = 6;
	localparam int F_DEBF      = 7;
	localparam int F_BUCK_EN   = 0;
	localparam int F_AMODE_LSB = 0;
	localparam int F_BMODE_LSB = 2;
	localparam int F_VSEL      = 4;
	localparam int F_M_PGSTAT  = 0;
	localparam int F_M_VRHOT   = 3;
	// ------------------------------------------------------------
	// Pin modes and edge selects
	// ------------------------------------------------------------
	localparam logic [3:0] MD_OFF    = 4'h0;
	localparam logic [3:0] MD_EN     = 4'h1;
	localparam logic [3:0] MD_DVC    = 4'h4;
	localparam logic [3:0] MD_RELOAD = 4'h7;
	localparam logic [3:0] MD_PG     = 4'h8;
	localparam logic [3:0] MD_SG     = 4'hB;
	localparam logic [3:0] MD_IRQ    = 4'hC;
	localparam logic [3:0] MD_LOW    = 4'hE;
	localparam logic [3:0] MD_HIGH   = 4'hF;
	localparam logic [1:0] TRG_RISE  = 2'h0;
	localparam logic [1:0] TRG_FALL  = 2'h1;
	localparam logic [1:0] TRG_BOTH  = 2'h2;
	// ------------------------------------------------------------
	// Configuration images, byte k lands at CFG_ADR[k]
	// ------------------------------------------------------------
	localparam logic [6:0] SLV_DEF = 7'h68;
	localparam int         CFG_N   = 10;
	localparam logic [7:0] CFG_ADR [CFG_N] = '{ADR_SLV, ADR_BUCK0,
		ADR_BUCK4, ADR_VOUTA, ADR_VOUTB, ADR_MASK3, 8'h12, 8'h13,
		8'h14, 8'h15};
	localparam logic [79:0] CFG0_DEF = 80'h0000_0000_0000_0000_0068;
	localparam logic [79:0] CFG1_DEF = 80'h0000_0000_0000_0000_0069;
	localparam logic [79:0] CFG2_DEF = 80'h0000_0000_0000_0000_006A;
	typedef enum logic [3:0] {I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK,
		I_WDATA, I_WACK, I_RDATA, I_MACK} pic_i2c_e;
endpackage

//--- hw/pic_deb.sv
// Input synchroniser, deglitch filter and edge-event detector
`timescale 1ns/10ps
`default_nettype none
module pic_deb #(
	parameter int LIM0 = pic_pkg::DEB_CYC_0,
	parameter int LIM1 = pic_pkg::DEB_CYC_1,
	parameter int LIM2 = pic_pkg::DEB_CYC_2,
	parameter int LIM3 = pic_pkg::DEB_CYC_3,
	parameter int CW   = 25
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Raw input and filter setup
	input  wire logic       raw,
	input  wire logic [1:0] deb_sel,
	input  wire logic [1:0] trig,
	input  wire logic       deb_rise,
	input  wire logic       deb_fall,
	// Filtered level and edge event
	output logic            level,
	output logic            event_pulse
);
	import pic_pkg::*;

	if (LIM0 < 1 || LIM1 < 1 || LIM2 < 1 || LIM3 < 1 ||
		LIM0 >= 2**CW || LIM1 >= 2**CW || LIM2 >= 2**CW ||
		LIM3 >= 2**CW) begin : g_bad_lim
		$error("pic_deb: filter length out of range");
	end

	logic          s1;
	logic          s2;
	logic [CW-1:0] cnt;
	logic [CW-1:0] lim_cur;
	logic          slow;
	logic          next_level;
	logic          hit;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
		end else begin
			s1 <= raw;
			s2 <= s1;
		end
	end

	always_comb begin
		case (deb_sel)
			2'h0: lim_cur = CW'(LIM0);
			2'h1: lim_cur = CW'(LIM1);
			2'h2: lim_cur = CW'(LIM2);
			default: lim_cur = CW'(LIM3);
		endcase
		slow = s2 ? deb_rise : deb_fall;
		next_level = level;
		if (s2 != level && (!slow || cnt == lim_cur - CW'(1)))
			next_level = s2;
		case (trig)
			TRG_RISE: hit = next_level;
			TRG_FALL: hit = !next_level;
			TRG_BOTH: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// Level moves after the new value held for the chosen time, or at once where deb_rise or deb_fall leaves that edge unfiltered
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level <= 1'b0;
			cnt <= '0;
		end else begin
			level <= next_level;
			if (s2 == level || next_level != level)
				cnt <= '0;
			else
				cnt <= cnt + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			event_pulse <= 1'b0;
		else
			event_pulse <= (next_level != level) && hit;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_deglitch_time: assert property (
		(level != $past(level)) && $past(slow)
		|-> $past(cnt) == $past(lim_cur) - CW'(1))
		else $error("filtered level moved before its hold time");
	a_fast_follow: assert property (
		(s2 != level) && !slow |=> level == $past(s2))
		else $error("unfiltered edge not taken at once");
	a_hold_stable: assert property (
		s2 == level |=> level == $past(level) && cnt == '0)
		else $error("filtered level changed without cause");
endmodule // pic_deb
`default_nettype wire

//--- sim/pic_host.sv
// I2C master model of the host processor
`timescale 1ns/10ps
`default_nettype none
module pic_host (
	// Clock and bus lines
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	logic [6:0] sa;
	initial begin
		sa = 7'h68;
		scl = 1'h1;
		sda_drv = 1'h1;
	end
	task automatic ph();
		repeat (8) @(negedge clk);
	endtask
	task automatic bx(input logic v, output logic r);
		sda_drv = v;
		ph();
		scl = 1'h1;
		ph();
		r = sda;
		scl = 1'h0;
		ph();
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic byx(input logic [7:0] b, input logic ma,
		output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bx(b[i], r[i]);
		bx(!ma, a);
		ack = !a;
	endtask
	task automatic start();
		sda_drv = 1'h1;
		ph();
		scl = 1'h1;
		ph();
		sda_drv = 1'h0;
		ph();
		scl = 1'h0;
		ph();
	endtask
	task automatic stop();
		sda_drv = 1'h0;
		ph();
		scl = 1'h1;
		ph();
		sda_drv = 1'h1;
		ph();
	endtask
	task automatic wr(input logic [7:0] a, v, output logic ok);
		logic [7:0] r;
		logic       k1, k2, k3;
		start();
		byx({sa, 1'h0}, 1'h0, r, k1);
		byx(a, 1'h0, r, k2);
		byx(v, 1'h0, r, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask
	// Pointer write, repeated start, data byte, no acknowledge, stop
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic       k1, k2, k3, x;
		start();
		byx({sa, 1'h0}, 1'h0, d, k1);
		byx(a, 1'h0, d, k2);
		start();
		byx({sa, 1'h1}, 1'h0, d, k3);
		byx(8'hFF, 1'h0, d, x);
		stop();
		ok = k1 & k2 & k3;
	endtask
endmodule // pic_host
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking testbench of the PMIC system-control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pic_pkg::*;
	localparam logic [3:0] MDS [5] = '{MD_PG, MD_SG, MD_LOW, MD_HIGH, MD_OFF};
	localparam logic [7:0] MEX [5] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h03};
	logic        clk = 1'h0, arst_n = 1'h0, ce = 1'h0, twarn = 1'h0;
	logic        scl, sda_h, ok, irq_n, b_pd;
	logic [2:0]  src = 3'h0;
	logic        ov = 1'h0, allow = 1'h0, cpu = 1'h0, cpd = 1'h0;
	logic [4:0]  pout, poe_n, pin;
	logic [7:0]  d;
	logic [31:0] rnd = 32'h0000_acc4;
	int          miscompares = 0, tests_run = 0;
	always #2.5 clk = ~clk;
	assign pin = {sda_h & (poe_n[4] | pout[4]), scl, ~poe_n[2:0] & pout[2:0]};
	pic_host H (.clk(clk), .sda(pin[4]), .scl(scl), .sda_drv(sda_h));
	pic_ctl #(.DEB_CYC_0(20), .DEB_CYC_1(40), .DEB_CYC_2(60), .DEB_CYC_3(80)) DUT (
		.clk(clk), .arst_n(arst_n), .chip_enable_pin(ce), .i2c_enable(1'h1),
		.setup_pin_allow(allow), .thermal_warn_raw(twarn),
		.thermal_crit_raw(src[2]), .overvolt_raw(ov), .undervolt_raw(src[1]),
		.overcurrent_raw(src[0]), .setup_select_pin_pu(cpu),
		.setup_select_pin_pd(cpd), .pin_in(pin), .pin_out(pout),
		.pin_oe_n(poe_n), .pin_pull_enable(), .interrupt_out_n(irq_n),
		.buck_enable(), .buck_pulldown(b_pd), .voltage_set_choice(),
		.voltage_code(), .op_mode());
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic w(input logic [7:0] a, v);
		H.wr(a, v, ok);
		chk({7'h0, ok}, 8'h01);
	endtask
	task automatic r(input logic [7:0] a, m, e);
		H.rd(a, d, ok);
		chk({7'h0, ok}, 8'h01);
		chk(d & m, e);
	endtask
	task automatic hit(input int k);
		src[k] = 1'h1;
		@(negedge clk);
		src[k] = 1'h0;
		repeat (6) @(negedge clk);
	endtask
	task automatic clr();
		w(ADR_EVT0, 8'hFF);
		w(ADR_EVT1, 8'hFF);
		w(ADR_EVT2, 8'hFF);
		@(negedge clk);
	endtask
	initial begin
		#400_000;
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1'h1;
		ce = 1'h1;
		repeat (10) @(negedge clk);
		clr();
		chk(irq_n, 1'h1);
		for (int k = 0; k < 3; k++) begin
			hit(k);
			chk(irq_n, 1'h0);
			w(k == 2 ? ADR_EVT0 : ADR_EVT1, 8'h00);
			r(k == 2 ? ADR_EVT0 : ADR_EVT1, k ? 2 : 1, k ? 2 : 1);
			clr();
			chk(irq_n, 1'h1);
		end
		w(ADR_MASK1, 8'h01);
		hit(0);
		chk(irq_n, 1'h1);
		r(ADR_EVT1, 8'h01, 8'h01);
		for (int i = 0; i < 4; i++) begin
			rnd = nx(rnd);
			w(ADR_MASK2, rnd[7:0]);
			r(ADR_MASK2, 8'h07, {5'h0, rnd[2:0]});
		end
		w(ADR_MASK2, 8'h07);
		w(ADR_MASK0, 8'h07);
		twarn = 1'h1;
		repeat (6) @(negedge clk);
		chk(irq_n, 1'h0);
		w(ADR_MASK3, 8'h08);
		chk(irq_n, 1'h1);
		r(ADR_STAT0, 8'h01, 8'h01);
		w(ADR_MASK3, 8'h00);
		twarn = 1'h0;
		repeat (6) @(negedge clk);
		chk(irq_n, 1'h1);
		foreach (MDS[i]) begin
			w(8'h12, {3'h0, MDS[i], 1'h0});
			@(negedge clk);
			chk({6'h0, poe_n[1], pout[1] | poe_n[1]}, MEX[i]);
		end
		clr();
		w(ADR_MASK1, 8'h00);
		w(8'h14, {3'h0, MD_IRQ, 1'h0});
		chk({6'h0, poe_n[2], pout[2]}, 8'h01);
		hit(0);
		chk({6'h0, poe_n[2], pout[2]}, 8'h00);
		w(ADR_SLV, 8'h55);
		H.sa = 7'h55;
		r(ADR_SLV, 8'h7F, 8'h55);
		H.sa = 7'h68;
		H.wr(ADR_MASK2, 8'h00, ok);
		chk({7'h0, ok}, 8'h00);
		ce = 1'h0;
		repeat (6) @(negedge clk);
		chk(b_pd, 1'h1);
		ce = 1'h1;
		repeat (10) @(negedge clk);
		r(ADR_SLV, 8'h7F, 8'h68);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
